// [verilog/mgmt_defines.svh]
// Constants for the module management control block: offsets, fields, reset values, timing.
// Assumes a 250 MHz register clock; included by the package, the checker and the bench.
`ifndef MGMT_DEFINES_SVH
`define MGMT_DEFINES_SVH

`define CLK_MHZ 250
`define INIT_TIME_MS 2000
`define INIT_CYCLES (`INIT_TIME_MS * 1000 * `CLK_MHZ)
`define RESET_MIN_US 2
`define RESET_MIN_CYCLES (`RESET_MIN_US * `CLK_MHZ)

`define OFS_STATUS 8'h00
`define OFS_FLAG 8'h04
`define OFS_MASK 8'h08
`define OFS_CONTROL 8'h0C

`define STATUS_NOT_READY_BIT 0
`define STATUS_LOW_POWER_BIT 1
`define STATUS_SERIAL_EN_BIT 2
`define STATUS_PENDING_BIT 3
`define CONTROL_POWER_DOWN_BIT 0

`define FLAG_READY_BIT 0
`define FLAG_RX_LOSS_BIT 1
`define FLAG_OTHER_LSB 2
`define FLAG_WIDTH 8

`define MASK_RESET 8'h00
`define FLAG_RESET 8'h00
`define RESET_CNT_WIDTH 10

`endif

// [verilog/mgmt_pkg.sv]
// Types shared by the module management control block.
// Assumes mgmt_defines.svh is on the include path.
`include "mgmt_defines.svh"

package mgmt_pkg;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_INIT,
      ST_READY
   } life_state_t;

   typedef logic [`FLAG_WIDTH-1:0] flag_vec_t;

   typedef struct packed {
      life_state_t st;
      logic [31:0] init_cnt;
      logic [`RESET_CNT_WIDTH-1:0] rst_cnt;
      logic rst_seen;
      logic [1:0] rst_sync;
      logic [1:0] sel_sync;
      logic [1:0] lp_sync;
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_prev;
      logic sda_prev;
      logic rst_prev;
      logic stop_seen;
      logic pend;
      flag_vec_t mask_pend;
      logic pd_pend;
      flag_vec_t mask;
      logic power_down;
      flag_vec_t flags;
      logic [31:0] prdata;
      logic pslverr;
      logic irq_n;
      logic low_power;
      logic serial_en;
   } mgmt_state_t;

endpackage

// [verilog/mgmt_control.sv]
// Management-side control and status sequencing of a pluggable module, with an APB slave.
// Assumes pin inputs and the serial clock and data are asynchronous to pclk; flag
// events come from logic on pclk. The serial bus itself is served elsewhere and is
// gated by serial_respond_en.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps

module mgmt_control
   import mgmt_pkg::*;
#(
   parameter logic [31:0] INIT_CYCLES = `INIT_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_request,
   input wire logic scl,
   input wire logic sda,
   input wire logic rx_signal_loss,
   input wire logic [`FLAG_WIDTH-`FLAG_OTHER_LSB-1:0] other_flag,
   output logic interrupt_n,
   output logic low_power_active,
   output logic serial_respond_en,
   output logic data_not_ready
);

   mgmt_state_t s_q;
   mgmt_state_t s_d;

   logic setup;
   logic access;
   logic wr;
   logic rd_flag;
   logic rst_rise;
   logic scl_fall;
   logic stop_cond;
   logic commit;
   flag_vec_t set_v;
   flag_vec_t clr_v;

   // Address decode is shared by the read path and the write path.
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `OFS_STATUS) || (a == `OFS_FLAG) || (a == `OFS_MASK)
         || (a == `OFS_CONTROL);
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] a, input mgmt_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (a)
         `OFS_STATUS:
         begin
            w[`STATUS_NOT_READY_BIT] = (s.st != ST_READY);
            w[`STATUS_LOW_POWER_BIT] = s.low_power;
            w[`STATUS_SERIAL_EN_BIT] = s.serial_en;
            w[`STATUS_PENDING_BIT] = s.pend;
         end
         `OFS_FLAG: w[`FLAG_WIDTH-1:0] = s.flags;
         `OFS_MASK: w[`FLAG_WIDTH-1:0] = s.mask;
         `OFS_CONTROL: w[`CONTROL_POWER_DOWN_BIT] = s.power_down;
         default: w = 32'h0000_0000;
      endcase
      read_word = w;
   endfunction

   always_comb
   begin
      s_d = s_q;

      // Pins pass two flops; only the second stage and later feed any logic.
      s_d.rst_sync = {s_q.rst_sync[0], module_reset_n};
      s_d.sel_sync = {s_q.sel_sync[0], module_select_n};
      s_d.lp_sync = {s_q.lp_sync[0], low_power_request};
      s_d.scl_sync = {s_q.scl_sync[0], scl};
      s_d.sda_sync = {s_q.sda_sync[0], sda};
      s_d.scl_prev = s_q.scl_sync[1];
      s_d.sda_prev = s_q.sda_sync[1];
      s_d.rst_prev = s_q.rst_sync[1];

      setup = psel && !penable;
      access = psel && penable;
      wr = access && pwrite;
      rd_flag = access && !pwrite && (paddr == `OFS_FLAG);

      rst_rise = s_q.rst_sync[1] && !s_q.rst_prev;
      scl_fall = !s_q.scl_sync[1] && s_q.scl_prev;
      stop_cond = s_q.scl_sync[1] && s_q.scl_prev && s_q.sda_sync[1] && !s_q.sda_prev;

      // A stop on the serial link arms the commit; the next serial clock fall fires it.
      if (stop_cond)
      begin
         s_d.stop_seen = 1'b1;
      end
      commit = s_q.stop_seen && scl_fall;
      if (commit)
      begin
         s_d.stop_seen = 1'b0;
      end

      // Reset pulses shorter than the minimum are filtered out.
      if (!s_q.rst_sync[1])
      begin
         if (s_q.rst_cnt != `RESET_CNT_WIDTH'(`RESET_MIN_CYCLES))
         begin
            s_d.rst_cnt = s_q.rst_cnt + 1'b1;
         end
         else
         begin
            s_d.rst_seen = 1'b1;
         end
      end
      else
      begin
         s_d.rst_cnt = '0;
      end

      set_v = '0;
      unique case (s_q.st)
         ST_HOLD:
         begin
            s_d.init_cnt = '0;
            if (rst_rise)
            begin
               s_d.rst_seen = 1'b0;
               s_d.st = ST_INIT;
            end
         end
         ST_INIT:
         begin
            if (s_q.rst_seen)
            begin
               s_d.st = ST_HOLD;
            end
            else if (s_q.init_cnt >= INIT_CYCLES - 32'd1)
            begin
               s_d.st = ST_READY;
               set_v[`FLAG_READY_BIT] = 1'b1;
            end
            else
            begin
               s_d.init_cnt = s_q.init_cnt + 32'd1;
            end
         end
         ST_READY:
         begin
            if (s_q.rst_seen)
            begin
               s_d.st = ST_HOLD;
            end
         end
         // The unused state code falls back to the held state, so an upset cannot lock up.
         default:
         begin
            s_d.st = ST_HOLD;
         end
      endcase

      // Serial answering needs a finished start-up and an asserted select.
      s_d.serial_en = (s_d.st == ST_READY) && !s_q.sel_sync[1];

      // Flag events are level conditions sampled every cycle.
      set_v[`FLAG_RX_LOSS_BIT] = rx_signal_loss;
      set_v[`FLAG_WIDTH-1:`FLAG_OTHER_LSB] = other_flag;

      // A read clears only the bits it returned, so a flag raised after setup survives.
      clr_v = '0;
      if (rd_flag)
      begin
         clr_v = s_q.prdata[`FLAG_WIDTH-1:0];
      end
      if (wr && (paddr == `OFS_FLAG))
      begin
         clr_v = clr_v | pwdata[`FLAG_WIDTH-1:0];
      end
      // Set beats clear in the same cycle so no event is lost.
      s_d.flags = (s_q.flags & ~clr_v) | set_v;

      // Mask and power-down writes wait for the first serial clock fall after a stop before taking effect.
      if (wr && (paddr == `OFS_MASK))
      begin
         s_d.mask_pend = pwdata[`FLAG_WIDTH-1:0];
         s_d.pend = 1'b1;
      end
      if (wr && (paddr == `OFS_CONTROL))
      begin
         s_d.pd_pend = pwdata[`CONTROL_POWER_DOWN_BIT];
         s_d.pend = 1'b1;
      end
      if (commit && s_q.pend)
      begin
         s_d.mask = s_q.mask_pend;
         s_d.power_down = s_q.pd_pend;
         s_d.pend = 1'b0;
      end

      // Low power follows the pin at once; leaving it drops back to full power unless power_down is set.
      s_d.low_power = s_q.lp_sync[1] || s_d.power_down;

      // Interrupt stays low while any unmasked flag is latched.
      s_d.irq_n = ~|(s_d.flags & ~s_d.mask);

      if (setup)
      begin
         s_d.prdata = read_word(paddr, s_q);
         s_d.pslverr = !is_mapped(paddr);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '{
            st: ST_INIT,
            init_cnt: 32'h0000_0000,
            rst_cnt: '0,
            rst_seen: 1'b0,
            rst_sync: 2'h3,
            sel_sync: 2'h3,
            lp_sync: 2'h0,
            scl_sync: 2'h3,
            sda_sync: 2'h3,
            scl_prev: 1'b1,
            sda_prev: 1'b1,
            rst_prev: 1'b1,
            stop_seen: 1'b0,
            pend: 1'b0,
            mask_pend: `MASK_RESET,
            pd_pend: 1'b0,
            mask: `MASK_RESET,
            power_down: 1'b0,
            flags: `FLAG_RESET,
            prdata: 32'h0000_0000,
            pslverr: 1'b0,
            irq_n: 1'b1,
            low_power: 1'b0,
            serial_en: 1'b0
         };
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Zero-wait slave: the access phase always completes in its first cycle.
   assign pready = 1'b1;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr && psel && penable;
   assign interrupt_n = s_q.irq_n;
   assign low_power_active = s_q.low_power;
   assign serial_respond_en = s_q.serial_en;
   assign data_not_ready = (s_q.st != ST_READY);

endmodule

// [bench/host_link.sv]
// Host side of the two-wire link: drives the clock and data lines for frame edges.
// Both lines idle high as the pull-ups leave them; steps follow the 64 ns link period.
`timescale 1ns/1ps
module host_link
(
   output logic scl,
   output logic sda
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Start, pulse, stop, start, pulse, stop; the second fall commits pending writes, or the first after an earlier call's closing stop.
   task automatic stop_and_fall();
      sda = 1'b0;
      #32 scl = 1'b0;
      #32 scl = 1'b1;
      #32 sda = 1'b1;
      #32 sda = 1'b0;
      #32 scl = 1'b0;
      #32 scl = 1'b1;
      #32 sda = 1'b1;
   endtask
endmodule

// [bench/mgmt_control_properties.sv]
// Checker of the block's pin, start-up and interrupt timing.
// Sees only the block's ports; attached by the bind below.
`timescale 1ns/1ps
`include "mgmt_defines.svh"
module mgmt_control_properties
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_request,
   input wire logic rx_signal_loss,
   input wire logic [`FLAG_WIDTH-`FLAG_OTHER_LSB-1:0] other_flag,
   input wire logic interrupt_n,
   input wire logic low_power_active,
   input wire logic serial_respond_en,
   input wire logic data_not_ready
);
   logic [15:0] low_q;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_q <= '0;
      else
         low_q <= module_reset_n ? '0 : low_q + {15'h0000, low_q != 16'hFFFF};
   end
   // No flag event in either cycle, so nothing may hold the interrupt low.
   sequence flag_read;
      psel && !penable && !rx_signal_loss && other_flag == '0 ##1
      psel && penable && !pwrite && paddr == `OFS_FLAG && !rx_signal_loss && other_flag == '0;
   endsequence
   sequence short_pulse;
      $rose(module_reset_n) && low_q < 16'h0190 && !data_not_ready;
   endsequence
   a_read_clear: assert property (flag_read |=> interrupt_n)
      else $error("interrupt stays low after flag read");
   a_ready_irq: assert property ($fell(data_not_ready) |-> ##[0:2] !interrupt_n)
      else $error("no interrupt at start-up end");
   a_ready_serial: assert property ($fell(data_not_ready) && !module_select_n |->
      ##[0:8] serial_respond_en)
      else $error("serial bus not answered after start-up");
   a_select_on: assert property ($fell(module_select_n) && !data_not_ready |->
      ##[1:1000] serial_respond_en)
      else $error("select did not enable answering");
   a_select_off: assert property ($rose(module_select_n) |-> ##[1:1000] !serial_respond_en)
      else $error("deselect did not stop answering");
   a_lp_enter: assert property ($rose(low_power_request) |-> ##[1:1000] low_power_active)
      else $error("low power not entered");
   a_reset_long: assert property (!module_reset_n && low_q == 16'h0240 |->
      data_not_ready && !serial_respond_en)
      else $error("long reset pulse not recognised");
   a_reset_short: assert property (short_pulse |-> !data_not_ready [*8])
      else $error("short reset pulse restarted start-up");
endmodule
bind mgmt_control mgmt_control_properties chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .module_reset_n, .module_select_n, .low_power_request, .rx_signal_loss,
   .other_flag, .interrupt_n, .low_power_active, .serial_respond_en, .data_not_ready);

// [bench/tb.sv]
// Bench for the block: APB master, pin and flag drivers, serial host model.
// Assumes the package and host model compile first; start-up is cut to 100 cycles.
`timescale 1ns/1ps
`include "mgmt_defines.svh"
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, interrupt_n, low_power_active, serial_respond_en;
   logic data_not_ready, scl, sda, rx_signal_loss = 1'b0;
   logic module_reset_n = 1'b1, module_select_n = 1'b0, low_power_request = 1'b0;
   logic [5:0] other_flag = 6'h00;
   logic [6:0] f;
   int bad_count = 0, n_checks = 0;
   always #2 pclk = ~pclk;
   host_link host (.scl, .sda);
   mgmt_control #(.INIT_CYCLES(32'h0000_0064)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .module_reset_n, .module_select_n,
      .low_power_request, .scl, .sda, .rx_signal_loss, .other_flag, .interrupt_n,
      .low_power_active, .serial_respond_en, .data_not_ready);
   function automatic logic [31:0] flag_exp(input logic [6:0] v);
      return {24'h00_0000, v, 1'b0};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic commit();
      host.stop_and_fall();
      cyc(12);
   endtask
   task automatic ev(input logic [6:0] v);
      @(posedge pclk);
      rx_signal_loss <= v[0];
      other_flag <= v[6:1];
      @(posedge pclk);
      rx_signal_loss <= 1'b0;
      other_flag <= 6'h00;
      cyc(2);
   endtask
   task automatic wait_ready();
      for (int k = 0; k < 400 && data_not_ready !== 1'b0; k++)
         @(posedge pclk);
      cyc(2);
      chk(32'(data_not_ready), 32'h0);
      chk(32'(interrupt_n), 32'h0);
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // About 1300 cycles are expected; a limit of 25000 cycles means a hang.
   initial
   begin
      #100000;
      bad_count++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(53));
      cyc(3);
      presetn <= 1'b1;
      cyc(2);
      chk(32'(data_not_ready), 32'h1);
      wait_ready();
      chk(32'(serial_respond_en), 32'h1);
      apb(1'b0, `OFS_STATUS);
      chk(rd, 32'h4);
      apb(1'b0, `OFS_FLAG);
      chk(rd, 32'h1);
      repeat (7)
      begin
         cyc(1);
         chk(32'(interrupt_n), 32'h1);
         f = 7'($urandom_range(127, 1));
         ev(f);
         chk(32'(interrupt_n), 32'h0);
         apb(1'b0, `OFS_FLAG);
         chk(rd, flag_exp(f));
      end
      ev(7'h03);
      apb(1'b1, `OFS_FLAG, 32'h2);
      cyc(1);
      chk(32'(interrupt_n), 32'h0);
      apb(1'b1, `OFS_FLAG, 32'h4);
      cyc(1);
      chk(32'(interrupt_n), 32'h1);
      apb(1'b1, `OFS_MASK, 32'h2);
      apb(1'b0, `OFS_STATUS);
      chk(rd, 32'hC);
      commit();
      ev(7'h01);
      chk(32'(interrupt_n), 32'h1);
      apb(1'b0, `OFS_FLAG);
      chk(rd, 32'h2);
      apb(1'b1, `OFS_MASK);
      commit();
      ev(7'h01);
      chk(32'(interrupt_n), 32'h0);
      apb(1'b0, `OFS_FLAG);
      for (int d = 1; d >= 0; d--)
      begin
         apb(1'b1, `OFS_CONTROL, 32'(d));
         commit();
         chk(32'(low_power_active), 32'(d));
      end
      apb(1'b0, 8'h10);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      low_power_request <= 1'b1;
      cyc(10);
      chk(32'(low_power_active), 32'h1);
      low_power_request <= 1'b0;
      module_select_n <= 1'b1;
      cyc(10);
      chk(32'(serial_respond_en), 32'h0);
      module_select_n <= 1'b0;
      cyc(10);
      chk(32'(serial_respond_en), 32'h1);
      module_reset_n <= 1'b0;
      cyc(100);
      module_reset_n <= 1'b1;
      cyc(10);
      chk(32'(data_not_ready), 32'h0);
      module_reset_n <= 1'b0;
      cyc(600);
      chk(32'(data_not_ready), 32'h1);
      module_reset_n <= 1'b1;
      wait_ready();
      end_of_test();
   end
endmodule
